// File: dv/rch_host_model.sv
// Host model that issues SPI frames and step read commands
`timescale 1ns/1ps
module rch_host_model (
    input wire logic clk, // Main clock
    input wire logic go, // Launch one frame
    input wire logic good, // Frame carries valid command and CRC
    input wire logic [7:0] len, // Read command length in cycles
    output logic frame_start, // Frame start pulse
    output logic read_busy, // Step read in progress
    output logic frame_ok // Good frame pulse at frame end
);
    // ==========================================================
    // Frame sequencer
    logic [7:0] cnt_q = 8'h0; // Busy cycles left
    initial begin
        frame_start = 1'b0;
        read_busy = 1'b0;
        frame_ok = 1'b0;
    end
    // Start, hold busy, then flag a good frame only when asked
    always @(posedge clk) begin
        frame_start <= go;
        frame_ok <= 1'b0;
        if (go) begin
            cnt_q <= len;
            read_busy <= 1'b1;
        end else if (cnt_q > 8'h1) begin
            cnt_q <= cnt_q - 8'h1;
        end else if (read_busy) begin
            read_busy <= 1'b0;
            frame_ok <= good;
        end
    end
endmodule // rch_host_model

// File: dv/tb_top.sv
// Testbench for tallies, step buffering and host watchdog
`timescale 1ns/1ps
module tb_top;
    import rch_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic clk, rst = 1'b1, low_pwr = 1'b0, go = 1'b0, good = 1'b0; // Clock, reset, host control
    logic [1:0] sh_en = 2'h0, vo_en = 2'h0, sh_done = 2'h0, vo_done = 2'h0; // Tally inputs
    logic [1:0] mx_en = 2'h0, mx_start = 2'h0, st_done = 2'h0, wsel = 2'h0; // Sequencer, window
    logic [2:0] last_a = 3'h0, dly_a = 3'h0; // Sequence shape
    logic [15:0] dat_a = 16'h0; // Step data
    logic [7:0] len = 8'h4; // Read length
    logic dir = 1'b1, src = 1'b0, fmt = 1'b0, pol = 1'b0, gp = 1'b0; // Host pin setup
    logic frame_start, busy, frame_ok, lost, pin, oe; // Observed
    wire logic lost_s = lost, pin_s = pin, oe_s = oe; // Watchdog outputs seen through the top
    logic [1:0] ct_a, ct_b, sq_a, sq_b, mconv, sact; // Observed tallies
    logic [127:0] res_a, res_b; // Step results
    int fails = 0, tests_run = 0; // Counters
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // Instances
    rch_host_model u_host (.clk(clk), .go(go), .good(good), .len(len), .frame_start(frame_start),
        .read_busy(busy), .frame_ok(frame_ok));
    // Short windows so expiry fits the run
    rch_result_counters #(.WIN1_CYC(200), .WIN2_CYC(400), .WIN3_CYC(800)) DUT (.CLK(clk), .RST(rst),
        .LOW_POWER(low_pwr), .SHUNT_EN(sh_en), .VOLT_EN(vo_en),
        .SHUNT_DONE(sh_done), .VOLT_DONE(vo_done), .MUX_EN(mx_en), .MUX_START(mx_start),
        .MUX_LAST_STEP_A(last_a), .MUX_LAST_STEP_B(last_a), .MUX_DELAY_A(dly_a), .MUX_DELAY_B(dly_a),
        .STEP_DONE(st_done), .STEP_DATA_A(dat_a), .STEP_DATA_B(dat_a), .READ_BUSY(busy),
        .FRAME_START(frame_start), .FRAME_OK(frame_ok), .HOST_LOSS_WINDOW_SEL(wsel), .PIN0_DIRECTION(dir),
        .PIN0_SOURCE_SEL(src), .PIN0_FORMAT(fmt), .HOST_LOSS_POLARITY(pol), .PIN0_GP_LEVEL(gp),
        .CONVERSION_TALLY_A(ct_a), .CONVERSION_TALLY_B(ct_b), .SEQUENCE_TALLY_A(sq_a),
        .SEQUENCE_TALLY_B(sq_b), .MUX_CONVERT(mconv), .SEQ_ACTIVE(sact), .STEP_RESULT_A(res_a),
        .STEP_RESULT_B(res_b), .HOST_LOSS_OUTPUT(lost), .GENERAL_PIN0(pin), .GENERAL_PIN0_OE(oe));
    // ==========================================================
    // Shared helpers
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Selects the signal a bounded wait watches
    function automatic logic sig(input int w);
        case (w)
            0: return mconv[0];
            1: return ~busy;
            2: return lost_s;
            3: return pin_s;
            default: return ~pin_s;
        endcase
    endfunction
    // Counts cycles until the signal is high, gives up after 3000
    task automatic wait_hi(input int w, output int n);
        n = 0;
        while (sig(w) !== 1'b1) begin
            tick(1);
            n++;
            if (n > 3000) begin
                fails++;
                give_verdict();
            end
        end
    endtask
    task automatic frame(input logic g);
        int n;
        good = g;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(1);
        wait_hi(1, n);
        tick(1);
    endtask
    task automatic give_verdict();
        $display("Mismatches %0d of %0d checks", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    // Shunt counts on A with wrap, voltage counts on B, frame copy and clears
    task automatic t_conv();
        sh_en = 2'h1;
        vo_en = 2'h3;
        for (int i = 0; i < 5; i++) begin
            sh_done = 2'h1;
            vo_done = (i < 3) ? 2'h3 : 2'h0;
            tick(1);
            sh_done = 2'h0;
            vo_done = 2'h0;
            tick(1);
        end
        frame(1'b1);
        chk(ct_a, 2'h1);
        chk(ct_b, 2'h3);
        sh_done = 2'h1;
        tick(1);
        sh_done = 2'h0;
        tick(2);
        chk(ct_a, 2'h1);
        vo_en = 2'h1;
        low_pwr = 1'b1;
        tick(1);
        low_pwr = 1'b0;
        frame(1'b1);
        chk({ct_a, ct_b}, 4'h0);
        vo_en = 2'h3;
    endtask
    // Two-step sequence, optionally finishing during a read
    task automatic run_seq(input logic [2:0] code, input logic hold, input logic [15:0] base);
        int n;
        dly_a = code;
        mx_start = 2'h1;
        tick(1);
        mx_start = 2'h0;
        for (int s = 0; s < 2; s++) begin
            wait_hi(0, n);
            chk(n >= (code + 1) * 64 - 2 && n <= (code + 1) * 64 + 2, 1'b1);
            if (hold && s == 1) begin
                len = 8'hc8;
                frame_go();
            end
            dat_a = base + 16'(s);
            st_done = 2'h1;
            tick(1);
            st_done = 2'h0;
        end
        tick(4);
    endtask
    task automatic frame_go();
        good = 1'b1;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(2);
    endtask
    task automatic t_seq();
        int n;
        mx_en = 2'h3;
        last_a = 3'h1;
        run_seq(3'h0, 1'b0, 16'h1100);
        chk(res_a[31:0], 32'h11011100);
        chk(sq_a, 2'h1);
        run_seq(3'h3, 1'b1, 16'h2200);
        chk(res_a[31:0], 32'h11011100);
        chk(sq_a, 2'h1);
        wait_hi(1, n);
        tick(3);
        chk(res_a[31:0], 32'h22012200);
        chk(sq_a, 2'h2);
        len = 8'h4;
        mx_en = 2'h2;
        tick(3);
        chk(sq_a, 2'h0);
    endtask
    // Every window code, sticky loss, restart by good frames only
    task automatic t_wdog();
        int n;
        for (int i = 1; i < 4; i++) begin
            wsel = 2'h0;
            tick(2);
            wsel = i[1:0];
            wait_hi(2, n);
            chk(n >= (100 << i) - 3 && n <= (100 << i) + 3, 1'b1);
            tick(2);
            chk({pin_s, oe_s}, 2'h1);
        end
        frame(1'b1);
        chk(lost_s, 1'b1);
        wsel = 2'h0;
        tick(2);
        chk({lost_s, pin_s}, 2'h1);
        chk(lost, 1'b0);
        wsel = 2'h1;
        repeat (6) begin
            tick(100);
            frame(1'b1);
        end
        chk(lost_s, 1'b0);
        repeat (3) begin
            tick(60);
            frame(1'b0);
        end
        tick(40);
        chk(lost_s, 1'b1);
        pol = 1'b1;
        tick(2);
        chk(pin_s, 1'b1);
        pol = 1'b0;
        wsel = 2'h0;
        tick(900);
        chk(lost_s, 1'b0);
    endtask
    // Heartbeat while inactive, static level once lost
    task automatic t_hb();
        int n;
        fmt = 1'b1;
        wait_hi(4, n);
        wait_hi(3, n);
        wait_hi(4, n);
        chk(n >= RCH_HB_HALF_CYC - 2 && n <= RCH_HB_HALF_CYC + 2, 1'b1);
        wsel = 2'h1;
        wait_hi(2, n);
        tick(600);
        chk(pin_s, 1'b0);
        fmt = 1'b0;
        wsel = 2'h0;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        tick(8);
        chk({pin, oe, lost, ct_a}, 5'h10);
        rst = 1'b0;
        tick(2);
        chk({pin, oe}, 2'h3);
        t_conv();
        t_seq();
        t_wdog();
        t_hb();
        give_verdict();
    end
endmodule // tb_top

// File: hw/rch_host_watchdog.sv
// Host-loss watchdog with pin formatting
`timescale 1ns/1ps
module rch_host_watchdog
    import rch_pkg::*;
#(
    parameter int WIN1_CYC = rch_pkg::RCH_WIN1_CYC,
    parameter int WIN2_CYC = rch_pkg::RCH_WIN2_CYC,
    parameter int WIN3_CYC = rch_pkg::RCH_WIN3_CYC
) (
    input wire logic clk, // Main clock
    input wire logic rst, // Async reset, active high
    input wire logic frame_ok, // Frame with valid command and CRC
    input wire logic [1:0] window_sel, // Host-loss window select
    input wire logic fmt, // Pin format, 0 static
    input wire logic pol, // Polarity, 0 active low
    input wire logic dir, // Pin direction, 1 output
    input wire logic src_sel, // Pin source, 0 host loss
    input wire logic gp_level, // General purpose level when not host loss
    output logic lost_q, // Host-loss state
    output logic pin_q, // Pin output level
    output logic pin_oe_q // Pin output enable
);
    // ==========================================================
    // Watchdog timer
    logic [24:0] wdt_q; // Cycles since last good frame
    logic [24:0] wdt_d; // Next timer value
    logic [8:0] hb_q; // Heartbeat divider
    logic hb_ph_q; // Heartbeat phase
    wire logic enabled = (window_sel != RCH_WIN_OFF); // Nonzero code enables
    wire logic [24:0] limit = (window_sel == 2'h1) ? WIN1_CYC[24:0] :
                              (window_sel == 2'h2) ? WIN2_CYC[24:0] : WIN3_CYC[24:0];
    wire logic expire = enabled && !frame_ok && (wdt_q >= limit - 25'h1);
    wire logic active_lvl = pol; // Pol 0 gives low active
    wire logic idle_lvl = fmt ? (hb_ph_q ^ pol) : ~pol; // Heartbeat in inactive state
    wire logic lvl = lost_q ? active_lvl : idle_lvl;
    wire logic pin_d = src_sel ? gp_level : lvl;

    // Timer restart on good frame, held clear while disabled
    always_comb begin
        if (!enabled || frame_ok) begin
            wdt_d = RCH_WDT_RST;
        end else if (wdt_q == limit) begin
            wdt_d = wdt_q; // Hold at limit
        end else begin
            wdt_d = wdt_q + 25'h1;
        end
    end

    // Timer and sticky host-loss flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_q <= RCH_WDT_RST;
            lost_q <= 1'b0;
        end else begin
            wdt_q <= wdt_d;
            lost_q <= enabled && (lost_q || expire); // Sticky, cleared only by code 00
        end
    end

    // Heartbeat divider, 50 percent duty
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hb_q <= RCH_HB_RST;
            hb_ph_q <= 1'b0;
        end else if (hb_q == 9'(RCH_HB_HALF_CYC - 1)) begin
            hb_q <= RCH_HB_RST;
            hb_ph_q <= ~hb_ph_q;
        end else begin
            hb_q <= hb_q + 9'h1;
        end
    end

    // Registered pin outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_q <= 1'b1;
            pin_oe_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
            pin_oe_q <= dir;
        end
    end

    a_lost_sticky: assert property (@(posedge clk) disable iff (rst)
        lost_q && enabled |=> lost_q) else $error("host loss dropped while enabled");
    a_lost_clear: assert property (@(posedge clk) disable iff (rst)
        !enabled |=> !lost_q) else $error("host loss not cleared when off");
    a_frame_restart: assert property (@(posedge clk) disable iff (rst)
        frame_ok && !lost_q |=> !lost_q && wdt_q == 25'h0) else $error("good frame did not restart");
endmodule // rch_host_watchdog

// File: hw/rch_pkg.sv
// Package with constants and types for the result counters and host watchdog block
package rch_pkg;
    // ==========================================================
    // Widths and section count
    localparam int RCH_SECTIONS = 2;
    localparam int RCH_TALLY_W = 2;
    localparam int RCH_STEPS = 8;
    localparam int RCH_DATA_W = 16;
    localparam logic [1:0] RCH_TALLY_RST = 2'h0;
    // ==========================================================
    // Timing constants
    localparam int RCH_CLK_NS = 10;
    // Host-loss windows in microseconds, codes 01, 10, 11
    localparam int RCH_WIN1_US = 10000;
    localparam int RCH_WIN2_US = 50000;
    localparam int RCH_WIN3_US = 200000;
    localparam int RCH_WIN1_CYC = (RCH_WIN1_US * 1000) / RCH_CLK_NS;
    localparam int RCH_WIN2_CYC = (RCH_WIN2_US * 1000) / RCH_CLK_NS;
    localparam int RCH_WIN3_CYC = (RCH_WIN3_US * 1000) / RCH_CLK_NS;
    localparam int RCH_WDT_W = 25;
    localparam logic [24:0] RCH_WDT_RST = 25'h0;
    // Mux settle delay base: code n waits (n+1) * base cycles
    localparam int RCH_MUX_BASE_CYC = 64;
    localparam int RCH_MUX_W = 10;
    localparam logic [9:0] RCH_MUX_RST = 10'h0;
    // Heartbeat half period in cycles, gives 50 percent duty
    localparam int RCH_HB_HALF_CYC = 500;
    localparam int RCH_HB_W = 9;
    localparam logic [8:0] RCH_HB_RST = 9'h0;
    // ==========================================================
    // Codes
    localparam logic [1:0] RCH_WIN_OFF = 2'h0;
    // Mux sequencer states
    typedef enum logic [1:0] {RCH_MX_IDLE, RCH_MX_SETTLE, RCH_MX_CONV} rch_mx_t;
endpackage

// File: hw/rch_result_counters.sv
// Conversion and sequence tallies, step result buffering, mux delay and host-loss watchdog top
`timescale 1ns/1ps
module rch_result_counters #(
    parameter int WIN1_CYC = rch_pkg::RCH_WIN1_CYC, // Host-loss window for code 01, in cycles
    parameter int WIN2_CYC = rch_pkg::RCH_WIN2_CYC, // Host-loss window for code 10, in cycles
    parameter int WIN3_CYC = rch_pkg::RCH_WIN3_CYC // Host-loss window for code 11, in cycles
) (
    input wire logic CLK, // Main clock 100 MHz
    input wire logic RST, // Async reset, active high
    input wire logic LOW_POWER, // Standby or power-down mode
    input wire logic [1:0] SHUNT_EN, // Shunt converter enable per section
    input wire logic [1:0] VOLT_EN, // Pack voltage converter enable per section
    input wire logic [1:0] SHUNT_DONE, // Shunt conversion done pulse per section
    input wire logic [1:0] VOLT_DONE, // Voltage conversion done pulse per section
    input wire logic [1:0] MUX_EN, // Multiplexed converter enable
    input wire logic [1:0] MUX_START, // Sequence start pulse per mux converter
    input wire logic [2:0] MUX_LAST_STEP_A, // Last step index for converter A
    input wire logic [2:0] MUX_LAST_STEP_B, // Last step index for converter B
    input wire logic [2:0] MUX_DELAY_A, // Mux settle delay code A
    input wire logic [2:0] MUX_DELAY_B, // Mux settle delay code B
    input wire logic [1:0] STEP_DONE, // Step conversion done pulse
    input wire logic [15:0] STEP_DATA_A, // Step result A
    input wire logic [15:0] STEP_DATA_B, // Step result B
    input wire logic READ_BUSY, // Step result read command in progress
    input wire logic FRAME_START, // SPI frame start pulse, latches frame tallies
    input wire logic FRAME_OK, // Frame with valid command and CRC
    input wire logic [1:0] HOST_LOSS_WINDOW_SEL, // Host-loss window select
    input wire logic PIN0_DIRECTION, // 1 output
    input wire logic PIN0_SOURCE_SEL, // 0 host loss source
    input wire logic PIN0_FORMAT, // 0 static levels
    input wire logic HOST_LOSS_POLARITY, // 0 active low
    input wire logic PIN0_GP_LEVEL, // Level when general purpose source
    output logic [1:0] CONVERSION_TALLY_A, // Frame copy of section A tally
    output logic [1:0] CONVERSION_TALLY_B, // Frame copy of section B tally
    output logic [1:0] SEQUENCE_TALLY_A, // Tally for published step results A
    output logic [1:0] SEQUENCE_TALLY_B, // Tally for published step results B
    output logic [1:0] MUX_CONVERT, // Start conversion pulse after settle
    output logic [1:0] SEQ_ACTIVE, // Sequence in progress
    output logic [127:0] STEP_RESULT_A, // Step result regs A, 8 x 16
    output logic [127:0] STEP_RESULT_B, // Step result regs B, 8 x 16
    output logic HOST_LOSS_OUTPUT, // Host-loss state, no status flag
    output logic GENERAL_PIN0, // Pin0 output level
    output logic GENERAL_PIN0_OE // Pin0 output enable
);
    import rch_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [1:0] tally_inc(input logic [1:0] v);
        tally_inc = v + 2'h1; // Plain wrap, 11 to 00
    endfunction
    function automatic logic [9:0] settle_cycles(input logic [2:0] code);
        settle_cycles = 10'((int'(code) + 1) * RCH_MUX_BASE_CYC);
    endfunction

    // ==========================================================
    // Conversion tallies
    logic [1:0] conv_q [RCH_SECTIONS]; // Live tallies
    logic [1:0] conv_frame_q [RCH_SECTIONS]; // Frame-latched tallies
    wire logic [1:0] conv_clr = ~(SHUNT_EN | VOLT_EN) | {2{LOW_POWER}};
    // Shunt done counts; voltage done counts only when shunt off
    wire logic [1:0] conv_evt = (SHUNT_EN & SHUNT_DONE) | (~SHUNT_EN & VOLT_EN & VOLT_DONE);

    // Live tallies per section
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            conv_q[0] <= RCH_TALLY_RST;
            conv_q[1] <= RCH_TALLY_RST;
        end else begin
            for (int i = 0; i < RCH_SECTIONS; i++) begin
                if (conv_clr[i]) begin
                    conv_q[i] <= RCH_TALLY_RST;
                end else if (conv_evt[i]) begin
                    conv_q[i] <= tally_inc(conv_q[i]);
                end
            end
        end
    end

    // Snapshot at frame start with the results it carries
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            conv_frame_q[0] <= RCH_TALLY_RST;
            conv_frame_q[1] <= RCH_TALLY_RST;
        end else if (FRAME_START) begin
            conv_frame_q[0] <= conv_q[0];
            conv_frame_q[1] <= conv_q[1];
        end
    end
    assign CONVERSION_TALLY_A = conv_frame_q[0];
    assign CONVERSION_TALLY_B = conv_frame_q[1];

    // ==========================================================
    // Mux sequencers with settle delay
    rch_mx_t mx_q [2]; // Sequencer state
    logic [9:0] dly_q [2]; // Settle countdown
    logic [2:0] step_q [2]; // Current step index
    logic [1:0] conv_pulse_q; // Start conversion pulses
    logic [1:0] seq_done_q; // Sequence completed pulses
    logic [15:0] work_q [2][RCH_STEPS]; // Results being collected
    wire logic [2:0] last_step [2] = '{MUX_LAST_STEP_A, MUX_LAST_STEP_B};
    wire logic [2:0] dly_code [2] = '{MUX_DELAY_A, MUX_DELAY_B};
    wire logic [15:0] sdata [2] = '{STEP_DATA_A, STEP_DATA_B};
    wire logic [1:0] mx_off = ~MUX_EN | {2{LOW_POWER}};

    // Per converter sequencer: settle, convert, next step
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int c = 0; c < 2; c++) begin
                mx_q[c] <= RCH_MX_IDLE;
                dly_q[c] <= RCH_MUX_RST;
                step_q[c] <= 3'h0;
                for (int s = 0; s < RCH_STEPS; s++) begin
                    work_q[c][s] <= 16'h0;
                end
            end
            conv_pulse_q <= 2'h0;
            seq_done_q <= 2'h0;
        end else begin
            conv_pulse_q <= 2'h0;
            seq_done_q <= 2'h0;
            for (int c = 0; c < 2; c++) begin
                if (mx_off[c]) begin
                    mx_q[c] <= RCH_MX_IDLE;
                end else begin
                    unique case (mx_q[c])
                        RCH_MX_IDLE: begin
                            if (MUX_START[c]) begin
                                step_q[c] <= 3'h0;
                                dly_q[c] <= settle_cycles(dly_code[c]);
                                mx_q[c] <= RCH_MX_SETTLE;
                            end
                        end
                        RCH_MX_SETTLE: begin
                            if (dly_q[c] == 10'h1) begin
                                conv_pulse_q[c] <= 1'b1; // Settled, convert
                                mx_q[c] <= RCH_MX_CONV;
                            end else begin
                                dly_q[c] <= dly_q[c] - 10'h1;
                            end
                        end
                        RCH_MX_CONV: begin
                            if (STEP_DONE[c]) begin
                                work_q[c][step_q[c]] <= sdata[c];
                                if (step_q[c] == last_step[c]) begin
                                    seq_done_q[c] <= 1'b1;
                                    mx_q[c] <= RCH_MX_IDLE;
                                end else begin
                                    step_q[c] <= step_q[c] + 3'h1;
                                    dly_q[c] <= settle_cycles(dly_code[c]); // Same delay every step
                                    mx_q[c] <= RCH_MX_SETTLE;
                                end
                            end
                        end
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Sequence tallies and result publishing
    logic [1:0] seq_q [2]; // Live sequence tally
    logic [1:0] seq_pub_q [2]; // Tally of published results
    logic [15:0] pub_q [2][RCH_STEPS]; // Step result regs
    logic [15:0] buf_q [2][RCH_STEPS]; // Hold buffer during reads
    logic [1:0] buf_tally_q [2]; // Tally of buffered results
    logic [1:0] buf_full_q; // Buffer holds pending results
    // Publish when no read is ongoing
    wire logic [1:0] pub_new = seq_done_q & ~{2{READ_BUSY}};
    wire logic [1:0] pub_buf = buf_full_q & ~seq_done_q & ~{2{READ_BUSY}};
    wire logic [1:0] to_buf = seq_done_q & {2{READ_BUSY}};

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int c = 0; c < 2; c++) begin
                seq_q[c] <= RCH_TALLY_RST;
                seq_pub_q[c] <= RCH_TALLY_RST;
                buf_tally_q[c] <= RCH_TALLY_RST;
                for (int s = 0; s < RCH_STEPS; s++) begin
                    pub_q[c][s] <= 16'h0;
                    buf_q[c][s] <= 16'h0;
                end
            end
            buf_full_q <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (mx_off[c]) begin
                    seq_q[c] <= RCH_TALLY_RST;
                    seq_pub_q[c] <= RCH_TALLY_RST;
                    buf_full_q[c] <= 1'b0;
                end else begin
                    if (seq_done_q[c]) begin
                        seq_q[c] <= tally_inc(seq_q[c]);
                    end
                    if (pub_new[c]) begin
                        pub_q[c] <= work_q[c];
                        seq_pub_q[c] <= tally_inc(seq_q[c]); // Tally with its results
                        buf_full_q[c] <= 1'b0;
                    end else if (to_buf[c]) begin
                        buf_q[c] <= work_q[c]; // Held, step regs untouched
                        buf_tally_q[c] <= tally_inc(seq_q[c]);
                        buf_full_q[c] <= 1'b1;
                    end else if (pub_buf[c]) begin
                        pub_q[c] <= buf_q[c]; // After read completes
                        seq_pub_q[c] <= buf_tally_q[c];
                        buf_full_q[c] <= 1'b0;
                    end
                end
            end
        end
    end

    assign SEQUENCE_TALLY_A = seq_pub_q[0];
    assign SEQUENCE_TALLY_B = seq_pub_q[1];
    assign MUX_CONVERT = conv_pulse_q;
    always_comb begin
        SEQ_ACTIVE[0] = (mx_q[0] != RCH_MX_IDLE);
        SEQ_ACTIVE[1] = (mx_q[1] != RCH_MX_IDLE);
    end
    assign STEP_RESULT_A = {pub_q[0][7], pub_q[0][6], pub_q[0][5], pub_q[0][4],
                            pub_q[0][3], pub_q[0][2], pub_q[0][1], pub_q[0][0]};
    assign STEP_RESULT_B = {pub_q[1][7], pub_q[1][6], pub_q[1][5], pub_q[1][4],
                            pub_q[1][3], pub_q[1][2], pub_q[1][1], pub_q[1][0]};

    // ==========================================================
    // Host-loss watchdog, shown on HOST_LOSS_OUTPUT and on the pin
    rch_host_watchdog #(
        .WIN1_CYC(WIN1_CYC),
        .WIN2_CYC(WIN2_CYC),
        .WIN3_CYC(WIN3_CYC)
    ) u_wdt (
        .clk(CLK),
        .rst(RST),
        .frame_ok(FRAME_OK),
        .window_sel(HOST_LOSS_WINDOW_SEL),
        .fmt(PIN0_FORMAT),
        .pol(HOST_LOSS_POLARITY),
        .dir(PIN0_DIRECTION),
        .src_sel(PIN0_SOURCE_SEL),
        .gp_level(PIN0_GP_LEVEL),
        .lost_q(HOST_LOSS_OUTPUT),
        .pin_q(GENERAL_PIN0),
        .pin_oe_q(GENERAL_PIN0_OE)
    );

    // ==========================================================
    // Checks
    a_conv_wrap: assert property (@(posedge CLK) disable iff (RST)
        conv_evt[0] && !conv_clr[0] |=> conv_q[0] == 2'($past(conv_q[0]) + 2'h1))
        else $error("conversion tally did not step");
    a_conv_clear: assert property (@(posedge CLK) disable iff (RST)
        LOW_POWER |=> conv_q[0] == 2'h0 && conv_q[1] == 2'h0) else $error("tally not cleared");
    a_no_overwrite: assert property (@(posedge CLK) disable iff (RST)
        READ_BUSY && $past(READ_BUSY) |-> $stable(STEP_RESULT_A)) else $error("step regs changed in read");
endmodule // rch_result_counters
